// file: core/arim_monitor.sv
// Purpose: acceleration-range and incremental-position safety monitors, one axis
// Assumes: safe feedback and fieldbus bits are on clk_sys; safe inputs are pins
// Notes:   register port answers every read one cycle later, never stalls
//
// Notes on behaviour
// - active accel monitor compares against limit window
// - accel outside window raises fault-activate
// - three independent instances of each monitor
// - activation from fieldbus or mapped safe input
// - each instance gives active status, fault-activate
// - reaction selectable, torque off default
// - after fault stays active, state failed (2)
// - active status reaches pulse-tested output only mapped
// - active increment monitor checks position window
// - capture safe position at activation as reference
// - bounds are reference plus upper, minus lower
// - position outside window raises fault-activate
// - optional start delay before window checks
`timescale 1ns/10ps
module arim_monitor import arim_pkg::*; #(
	parameter int unsigned MS_CYCLES = CYC_PER_MS
) (
	// clock and reset
	input  wire logic                     clk_sys,
	input  wire logic                     sys_rst,
	// register port
	input  wire logic [ADDR_W-1:0]        reg_addr,
	input  wire logic [31:0]              reg_wdata,
	input  wire logic                     reg_wr,
	input  wire logic                     reg_rd,
	output logic      [31:0]              reg_rdata,
	// activation sources
	input  wire logic [N_INST-1:0]        bus_act_accel,
	input  wire logic [N_INST-1:0]        bus_act_incr,
	input  wire logic [N_SIN-1:0]         safe_in,
	// safe feedback
	input  wire logic signed [ACC_W-1:0]  safe_accel,
	input  wire logic signed [POS_W-1:0]  safe_pos,
	// per-instance status
	output logic      [N_INST-1:0]        accel_monitor_active_flag,
	output logic      [N_INST-1:0]        accel_fault_activate,
	output logic      [N_INST-1:0]        incr_active_flag,
	output logic      [N_INST-1:0]        incr_fault_activate,
	// fault reactions
	output logic                          torque_off_reaction,
	output logic                          stop_one_reaction,
	output logic                          stop_two_reaction,
	// pulse-tested outputs and interrupt
	output logic      [N_PTO-1:0]         pulse_tested_output,
	output logic                          irq
);

	// ==========================================================
	// helpers
	// window test on sign-extended values, lower and upper inclusive
	function automatic logic in_window(input logic signed [POS_W:0] v,
		input logic signed [POS_W:0] lo, input logic signed [POS_W:0] hi);
		in_window = (v >= lo) && (v <= hi);
	endfunction

	// activation decode shared by both monitor kinds
	function automatic logic act_sel(input logic [CFG_W-1:0] cfg, input logic bus_bit,
		input logic [N_SIN-1:0] sin);
		logic [1:0] src;
		src = cfg[CFG_SRC_LSB +: 2];
		act_sel = (src == SRC_BUS) ? bus_bit :
			(src == SRC_SIN) ? sin[cfg[CFG_SIN_LSB +: 2]] : 1'b0;
	endfunction

	function automatic logic [7:0] acc_ofs(input int i, input logic [7:0] f);
		acc_ofs = OFS_ACC_BASE + 8'(i) * OFS_INST_STR + f;
	endfunction

	function automatic logic [7:0] inc_ofs(input int i, input logic [7:0] f);
		inc_ofs = OFS_INC_BASE + 8'(i) * OFS_INST_STR + f;
	endfunction

	// ==========================================================
	// safe input synchroniser
	logic [N_SIN-1:0] sin_meta_r;
	logic [N_SIN-1:0] sin_r;

	// pins are asynchronous to clk_sys
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			sin_meta_r <= '0;
			sin_r      <= '0;
		end else begin
			sin_meta_r <= safe_in;
			sin_r      <= sin_meta_r;
		end
	end

	// ==========================================================
	// configuration registers, one set per instance, plus the shared output map and irq mask
	logic [CFG_W-1:0]        acc_cfg_r [N_INST];
	logic signed [ACC_W-1:0] acc_ul_r  [N_INST];
	logic signed [ACC_W-1:0] acc_ll_r  [N_INST];
	logic [CFG_W-1:0]        inc_cfg_r [N_INST];
	logic [POS_W-1:0]        inc_uo_r  [N_INST];
	logic [POS_W-1:0]        inc_lo_r  [N_INST];
	logic [DLY_W-1:0]        inc_dly_r [N_INST];
	logic [8:0]              map_r;
	logic [2*N_INST-1:0]     irq_mask_r;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < N_INST; i++) begin
				acc_cfg_r[i] <= CFG_RST;
				acc_ul_r[i]  <= ACC_LIM_RST;
				acc_ll_r[i]  <= ACC_LIM_RST;
				inc_cfg_r[i] <= CFG_RST;
				inc_uo_r[i]  <= POS_OFS_RST;
				inc_lo_r[i]  <= POS_OFS_RST;
				inc_dly_r[i] <= DLY_RST;
			end
			map_r      <= MAP_RST;
			irq_mask_r <= '0;
		end else if (reg_wr) begin
			for (int i = 0; i < N_INST; i++) begin
				if (reg_addr == acc_ofs(i, OFS_CFG))   acc_cfg_r[i] <= reg_wdata[CFG_W-1:0];
				if (reg_addr == acc_ofs(i, OFS_UPPER)) acc_ul_r[i]  <= reg_wdata[ACC_W-1:0];
				if (reg_addr == acc_ofs(i, OFS_LOWER)) acc_ll_r[i]  <= reg_wdata[ACC_W-1:0];
				if (reg_addr == inc_ofs(i, OFS_CFG))   inc_cfg_r[i] <= reg_wdata[CFG_W-1:0];
				if (reg_addr == inc_ofs(i, OFS_UPPER)) inc_uo_r[i]  <= reg_wdata;
				if (reg_addr == inc_ofs(i, OFS_LOWER)) inc_lo_r[i]  <= reg_wdata;
				if (reg_addr == inc_ofs(i, OFS_DELAY)) inc_dly_r[i] <= reg_wdata[DLY_W-1:0];
			end
			if (reg_addr == OFS_OUT_MAP)  map_r      <= reg_wdata[8:0];
			if (reg_addr == OFS_IRQ_MASK) irq_mask_r <= reg_wdata[2*N_INST-1:0];
		end
	end

	// ==========================================================
	// millisecond tick for start delays
	logic [17:0] ms_cnt_r;
	logic        ms_tick_r;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			ms_cnt_r  <= '0;
			ms_tick_r <= 1'b0;
		end else if (ms_cnt_r == 18'(MS_CYCLES - 1)) begin
			ms_cnt_r  <= '0;
			ms_tick_r <= 1'b1;
		end else begin
			ms_cnt_r  <= ms_cnt_r + 18'h1;
			ms_tick_r <= 1'b0;
		end
	end

	// ==========================================================
	// acceleration-range monitors
	logic [1:0] acc_st_r [N_INST];
	logic [N_INST-1:0] acc_fail_ev;

	// failed state is kept until deactivated; fault does not end the function
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < N_INST; i++) acc_st_r[i] <= ST_INACTIVE;
		end else begin
			for (int i = 0; i < N_INST; i++) begin
				if (!act_sel(acc_cfg_r[i], bus_act_accel[i], sin_r)) begin
					acc_st_r[i] <= ST_INACTIVE;
				end else if (acc_st_r[i] == ST_INACTIVE) begin
					acc_st_r[i] <= ST_ACTIVE;
				end else if (acc_fail_ev[i]) begin
					acc_st_r[i] <= ST_FAILED;
				end
			end
		end
	end

	always_comb begin
		for (int i = 0; i < N_INST; i++) begin
			acc_fail_ev[i] = (acc_st_r[i] == ST_ACTIVE) &&
				!in_window(POS_W'(safe_accel) + 33'sd0, POS_W'(acc_ll_r[i]) + 33'sd0,
				POS_W'(acc_ul_r[i]) + 33'sd0);
		end
	end

	// ==========================================================
	// incremental-position monitors
	logic [1:0]       inc_st_r  [N_INST];
	logic [POS_W-1:0] captured_position [N_INST];
	logic [DLY_W-1:0] inc_wait_r [N_INST];
	logic [N_INST-1:0] inc_act_prev_r;
	logic [N_INST-1:0] inc_fail_ev;
	logic [N_INST-1:0] inc_act;

	always_comb begin
		for (int i = 0; i < N_INST; i++) begin
			inc_act[i] = act_sel(inc_cfg_r[i], bus_act_incr[i], sin_r);
		end
	end

	// reference and delay load on the activating edge only
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			inc_act_prev_r <= '0;
			for (int i = 0; i < N_INST; i++) begin
				captured_position[i] <= '0;
				inc_wait_r[i]        <= '0;
			end
		end else begin
			inc_act_prev_r <= inc_act;
			for (int i = 0; i < N_INST; i++) begin
				if (inc_act[i] && !inc_act_prev_r[i]) begin
					captured_position[i] <= safe_pos;
					inc_wait_r[i]        <= inc_dly_r[i];
				end else if (ms_tick_r && inc_wait_r[i] != '0) begin
					inc_wait_r[i] <= inc_wait_r[i] - 16'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			for (int i = 0; i < N_INST; i++) inc_st_r[i] <= ST_INACTIVE;
		end else begin
			for (int i = 0; i < N_INST; i++) begin
				if (!inc_act[i]) begin
					inc_st_r[i] <= ST_INACTIVE;
				end else if (inc_st_r[i] == ST_INACTIVE) begin
					inc_st_r[i] <= ST_ACTIVE;
				end else if (inc_fail_ev[i]) begin
					inc_st_r[i] <= ST_FAILED;
				end
			end
		end
	end

	// 33-bit bounds so that an offset up to 2^31 cannot wrap the window
	always_comb begin
		for (int i = 0; i < N_INST; i++) begin
			inc_fail_ev[i] = (inc_st_r[i] == ST_ACTIVE) && (inc_wait_r[i] == '0) &&
				!in_window({safe_pos[POS_W-1], safe_pos},
				{captured_position[i][POS_W-1], captured_position[i]} -
					{1'b0, inc_lo_r[i]},
				{captured_position[i][POS_W-1], captured_position[i]} +
					{1'b0, inc_uo_r[i]});
		end
	end

	// ==========================================================
	// status outputs and fault reactions
	logic [N_INST-1:0] acc_failed;
	logic [N_INST-1:0] inc_failed;
	logic [2:0]        react_nxt;

	always_comb begin
		react_nxt = '0;
		for (int i = 0; i < N_INST; i++) begin
			acc_failed[i] = acc_st_r[i] == ST_FAILED;
			inc_failed[i] = inc_st_r[i] == ST_FAILED;
			if (acc_failed[i]) react_nxt[acc_cfg_r[i][CFG_REACT_LSB +: 2]] = 1'b1;
			if (inc_failed[i]) react_nxt[inc_cfg_r[i][CFG_REACT_LSB +: 2]] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			accel_monitor_active_flag <= '0;
			accel_fault_activate      <= '0;
			incr_active_flag          <= '0;
			incr_fault_activate       <= '0;
			torque_off_reaction       <= 1'b0;
			stop_one_reaction         <= 1'b0;
			stop_two_reaction         <= 1'b0;
		end else begin
			for (int i = 0; i < N_INST; i++) begin
				accel_monitor_active_flag[i] <= acc_st_r[i] != ST_INACTIVE;
				incr_active_flag[i]          <= inc_st_r[i] != ST_INACTIVE;
			end
			accel_fault_activate <= acc_failed;
			incr_fault_activate  <= inc_failed;
			torque_off_reaction  <= react_nxt[REACT_TORQUE_OFF];
			stop_one_reaction    <= react_nxt[REACT_STOP_ONE];
			stop_two_reaction    <= react_nxt[REACT_STOP_TWO];
		end
	end

	// ==========================================================
	// pulse-tested output routing
	// selects 0 and 7 leave the output off; pair makes output 1 copy output 0
	logic [2*N_INST+1:0] route_src;
	assign route_src = {1'b0, incr_active_flag, accel_monitor_active_flag, 1'b0};

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_tested_output <= '0;
		end else begin
			pulse_tested_output[0] <= route_src[map_r[0 +: MAP_SEL_W]];
			pulse_tested_output[1] <= map_r[MAP_PAIR_BIT] ?
				route_src[map_r[0 +: MAP_SEL_W]] : route_src[map_r[MAP_SEL_W +: MAP_SEL_W]];
		end
	end

	// ==========================================================
	// interrupt status: set by fault entry, cleared by reading
	logic [2*N_INST-1:0] irq_stat_r;
	logic [2*N_INST-1:0] irq_set;
	logic                stat_rd;

	assign irq_set = {inc_fail_ev, acc_fail_ev};
	assign stat_rd = reg_rd && (reg_addr == OFS_IRQ_STAT);

	// set beats the read-clear so a fault in the read cycle survives
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_stat_r <= '0;
			irq        <= 1'b0;
		end else begin
			irq_stat_r <= (stat_rd ? '0 : irq_stat_r) | irq_set;
			irq        <= |(((stat_rd ? '0 : irq_stat_r) | irq_set) & irq_mask_r);
		end
	end

	// ==========================================================
	// read path
	logic [31:0] rd_nxt;

	always_comb begin
		rd_nxt = '0;
		unique case (reg_addr)
			OFS_IRQ_STAT: rd_nxt = 32'(irq_stat_r);
			OFS_IRQ_MASK: rd_nxt = 32'(irq_mask_r);
			OFS_OUT_MAP:  rd_nxt = 32'(map_r);
			OFS_STATE:    rd_nxt = {20'h0, inc_st_r[2], inc_st_r[1], inc_st_r[0],
				acc_st_r[2], acc_st_r[1], acc_st_r[0]};
			default: begin
				// signed limits read back zero-extended, upper bits stay 0
				for (int i = 0; i < N_INST; i++) begin
					if (reg_addr == acc_ofs(i, OFS_CFG))   rd_nxt = 32'(acc_cfg_r[i]);
					if (reg_addr == acc_ofs(i, OFS_UPPER)) rd_nxt = {{(32-ACC_W){1'b0}}, acc_ul_r[i]};
					if (reg_addr == acc_ofs(i, OFS_LOWER)) rd_nxt = {{(32-ACC_W){1'b0}}, acc_ll_r[i]};
					if (reg_addr == inc_ofs(i, OFS_CFG))   rd_nxt = 32'(inc_cfg_r[i]);
					if (reg_addr == inc_ofs(i, OFS_UPPER)) rd_nxt = inc_uo_r[i];
					if (reg_addr == inc_ofs(i, OFS_LOWER)) rd_nxt = inc_lo_r[i];
					if (reg_addr == inc_ofs(i, OFS_DELAY)) rd_nxt = 32'(inc_dly_r[i]);
				end
			end
		endcase
	end

	// data stand only in the cycle after the strobe; unmapped reads give zero
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rd_nxt : 32'h0;
		end
	end

endmodule

// file: include/arim_pkg.sv
// Purpose: shared constants for the acceleration-range and increment monitors
// Assumes: 250 MHz system clock, 32-bit register port with byte offsets
// Notes:   all offsets, field positions, timing counts and reset values except the irq mask's live here
package arim_pkg;
	// ==========================================================
	// sizes
	localparam int N_INST   = 3;
	localparam int ACC_W    = 16;
	localparam int POS_W    = 32;
	localparam int DLY_W    = 16;
	localparam int N_SIN    = 4;
	localparam int N_PTO    = 2;
	localparam int ADDR_W   = 8;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int DELAY_UNIT_NS = 1000000;  // delay counts in ms
	localparam int CYC_PER_MS    = DELAY_UNIT_NS / CLK_PERIOD_NS;

	// ==========================================================
	// register offsets
	localparam logic [7:0] OFS_IRQ_STAT = 8'h00;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h04;
	localparam logic [7:0] OFS_STATE    = 8'h08;
	localparam logic [7:0] OFS_OUT_MAP  = 8'h0c;
	localparam logic [7:0] OFS_ACC_BASE = 8'h10;
	localparam logic [7:0] OFS_INC_BASE = 8'h40;
	localparam logic [7:0] OFS_INST_STR = 8'h10;
	localparam logic [7:0] OFS_CFG      = 8'h00;
	localparam logic [7:0] OFS_UPPER    = 8'h04;
	localparam logic [7:0] OFS_LOWER    = 8'h08;
	localparam logic [7:0] OFS_DELAY    = 8'h0c;

	// ==========================================================
	// config fields: [1:0] source, [3:2] safe input, [5:4] reaction
	localparam int CFG_SRC_LSB   = 0;
	localparam int CFG_SIN_LSB   = 2;
	localparam int CFG_REACT_LSB = 4;
	localparam int CFG_W         = 6;
	localparam logic [1:0] SRC_NEVER = 2'h0;
	localparam logic [1:0] SRC_BUS   = 2'h1;
	localparam logic [1:0] SRC_SIN   = 2'h2;
	localparam logic [1:0] REACT_TORQUE_OFF = 2'h0;
	localparam logic [1:0] REACT_STOP_ONE   = 2'h1;
	localparam logic [1:0] REACT_STOP_TWO   = 2'h2;
	localparam logic [CFG_W-1:0] CFG_RST = 6'h00;

	// internal state indicator codes
	localparam logic [1:0] ST_INACTIVE = 2'h0;
	localparam logic [1:0] ST_ACTIVE   = 2'h1;
	localparam logic [1:0] ST_FAILED   = 2'h2;

	// output map: 3-bit select per output, pair bit
	localparam int MAP_SEL_W    = 3;
	localparam int MAP_PAIR_BIT = 8;
	localparam logic [8:0] MAP_RST = 9'h000;

	// reset values of limits and offsets
	localparam logic [ACC_W-1:0] ACC_LIM_RST = 16'h0001;
	localparam logic [POS_W-1:0] POS_OFS_RST = 32'h0000_0001;
	localparam logic [DLY_W-1:0] DLY_RST     = 16'h0000;
endpackage

// file: sim/arim_monitor_chk.sv
// Purpose: port-level checks of the monitor block
// Assumes: one clock domain, active-high safe inputs
// Notes:   config is not shadowed, so checks hold for any configuration
`timescale 1ns/10ps
module arim_monitor_chk import arim_pkg::*; (
	// clock and reset
	input wire logic              clk_sys,
	input wire logic              sys_rst,
	// register port and sources
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [31:0]       reg_rdata,
	input wire logic [N_INST-1:0] bus_act_accel,
	input wire logic [N_INST-1:0] bus_act_incr,
	input wire logic [N_SIN-1:0]  safe_in,
	// outputs watched
	input wire logic [N_INST-1:0] accel_monitor_active_flag,
	input wire logic [N_INST-1:0] accel_fault_activate,
	input wire logic [N_INST-1:0] incr_active_flag,
	input wire logic [N_INST-1:0] incr_fault_activate,
	input wire logic              torque_off_reaction,
	input wire logic              stop_one_reaction,
	input wire logic              stop_two_reaction,
	input wire logic              irq
);
	// ==========================================================
	// assertions
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	property p_acc_fault_active;
		(accel_fault_activate & ~accel_monitor_active_flag) == 3'h0;
	endproperty
	a_acc_fault_active: assert property (p_acc_fault_active) else $error("accel fault idle");
	property p_inc_fault_active;
		(incr_fault_activate & ~incr_active_flag) == 3'h0;
	endproperty
	a_inc_fault_active: assert property (p_inc_fault_active) else $error("incr fault idle");
	property p_fail_latched;
		1'b1 |=> (($past(accel_fault_activate) & accel_monitor_active_flag
			& ~accel_fault_activate) == 3'h0);
	endproperty
	a_fail_latched: assert property (p_fail_latched) else $error("accel fault dropped");
	property p_react_cause;
		(torque_off_reaction || stop_one_reaction || stop_two_reaction)
			|-> (|{accel_fault_activate, incr_fault_activate});
	endproperty
	a_react_cause: assert property (p_react_cause) else $error("reaction w/o fault");
	property p_acc_idle;
		(bus_act_accel == 3'h0 && safe_in == 4'h0) [*6] |-> accel_monitor_active_flag == 3'h0;
	endproperty
	a_acc_idle: assert property (p_acc_idle) else $error("accel active w/o source");
	property p_inc_idle;
		(bus_act_incr == 3'h0 && safe_in == 4'h0) [*6] |-> incr_active_flag == 3'h0;
	endproperty
	a_inc_idle: assert property (p_inc_idle) else $error("incr active w/o source");
	property p_irq_fault;
		$rose(irq) && !$past(reg_wr, 2) |=> (|{accel_fault_activate, incr_fault_activate});
	endproperty
	a_irq_fault: assert property (p_irq_fault) else $error("irq w/o fault");
	property p_rdata_idle;
		!$past(reg_rd) |-> reg_rdata == 32'h0;
	endproperty
	a_rdata_idle: assert property (p_rdata_idle) else $error("rdata w/o read");
endmodule

bind arim_monitor arim_monitor_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.bus_act_accel(bus_act_accel), .bus_act_incr(bus_act_incr), .safe_in(safe_in),
	.accel_monitor_active_flag(accel_monitor_active_flag),
	.accel_fault_activate(accel_fault_activate), .incr_active_flag(incr_active_flag),
	.incr_fault_activate(incr_fault_activate), .torque_off_reaction(torque_off_reaction),
	.stop_one_reaction(stop_one_reaction), .stop_two_reaction(stop_two_reaction),
	.irq(irq));

// file: sim/arim_partner.sv
// Purpose: safety controller model for activation levels and safe feedback
// Assumes: called by the bench right after a rising clk_sys edge
// Notes:   levels only; the controller maps a safe input before it raises it
`timescale 1ns/10ps
module arim_partner import arim_pkg::*; (
	// activation sources
	output logic        [N_INST-1:0] bus_act_accel,
	output logic        [N_INST-1:0] bus_act_incr,
	output logic        [N_SIN-1:0]  safe_in,
	// safe feedback
	output logic signed [ACC_W-1:0]  safe_accel,
	output logic signed [POS_W-1:0]  safe_pos
);
	// ==========================================================
	// level update, nonblocking so the edge in flight sees old values
	task automatic drive(input logic [N_INST-1:0] aa, input logic [N_INST-1:0] ai,
		input logic [N_SIN-1:0] si, input logic signed [ACC_W-1:0] ac,
		input logic signed [POS_W-1:0] ps);
		bus_act_accel <= aa;
		bus_act_incr  <= ai;
		safe_in       <= si;
		safe_accel    <= ac;
		safe_pos      <= ps;
	endtask

	// idle: nothing active, feedback at rest
	initial begin
		drive(3'h0, 3'h0, 4'h0, 16'sh0000, 32'sh0);
	end
endmodule

// file: sim/tb_arim_monitor.sv
// Purpose: directed bench for the monitor block
// Assumes: ms tick shortened to 10 cycles
// Notes:   waits are loose multiples of the fixed latencies
`timescale 1ns/10ps
module tb_arim_monitor import arim_pkg::*;;
	// ==========================================================
	// signals
	logic                     clk_sys = 1'b0;
	logic                     sys_rst = 1'b1;
	logic [ADDR_W-1:0]        reg_addr = 8'h00;
	logic [31:0]              reg_wdata = 32'h0;
	logic                     reg_wr = 1'b0;
	logic                     reg_rd = 1'b0;
	logic [31:0]              reg_rdata;
	logic [N_INST-1:0]        baa, bai, afl, afa, ifl, ifa;
	logic [N_SIN-1:0]         sin;
	logic signed [ACC_W-1:0]  acc;
	logic signed [POS_W-1:0]  pos;
	logic                     tq, s1, s2, irq;
	logic [N_PTO-1:0]         pto;
	int                       errors = 0;
	int                       samples_checked = 0;

	always #2 clk_sys = ~clk_sys;

	arim_partner partner_u (.bus_act_accel(baa), .bus_act_incr(bai), .safe_in(sin),
		.safe_accel(acc), .safe_pos(pos));
	arim_monitor #(.MS_CYCLES(10)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .bus_act_accel(baa), .bus_act_incr(bai), .safe_in(sin),
		.safe_accel(acc), .safe_pos(pos), .accel_monitor_active_flag(afl),
		.accel_fault_activate(afa), .incr_active_flag(ifl), .incr_fault_activate(ifa),
		.torque_off_reaction(tq), .stop_one_reaction(s1), .stop_two_reaction(s2),
		.pulse_tested_output(pto), .irq(irq));

	// ==========================================================
	// tasks
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1;
		chk("rdata", reg_rdata, e);
	endtask
	task automatic fb(input logic [2:0] aa, input logic [3:0] si,
		input logic signed [15:0] ac, input logic signed [31:0] ps);
		@(posedge clk_sys);
		partner_u.drive(aa, 3'h0, si, ac, ps);
	endtask
	task automatic report_and_stop();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// watchdog, far beyond the few hundred cycles needed
	initial begin
		#200000;
		errors++;
		report_and_stop();
	end

	// ==========================================================
	// main sequence
	initial begin
		repeat (8) @(posedge clk_sys);
		sys_rst <= 1'b0;
		// reset values, read-only state, unmapped place
		rd(8'h10, 32'h0);
		rd(8'h14, 32'h1);
		rd(8'h18, 32'h1);
		rd(8'h48, 32'h1);
		rd(8'h4c, 32'h0);
		rd(8'h0c, 32'h0);
		wr(8'h08, 32'hffff);
		rd(8'h08, 32'h0);
		rd(8'hfc, 32'h0);
		wr(8'h04, 32'h3f);
		// each accel instance with its own reaction, low exit for 0 and 2, high exit for 1
		for (int i = 0; i < 3; i++) begin
			wr(8'h10 + 8'(16 * i), 32'(i * 16 + 1));
			fb(3'(1 << i), 4'h0, 16'sh0001, 32'sh0);
			step(4);
			chk("acc act", afl, 32'(1 << i));
			chk("acc ok", afa, 32'h0);
			fb(3'(1 << i), 4'h0, (i == 1) ? 16'sh0002 : 16'sh0000, 32'sh0);
			step(4);
			chk("acc flt", afa, 32'(1 << i));
			chk("acc stay", afl, 32'(1 << i));
			chk("react", {s2, s1, tq}, 32'(1 << i));
			rd(8'h08, 32'(2 << (2 * i)));
			chk("irq", irq, 32'h1);
			rd(8'h00, 32'(1 << i));
			step(2);
			chk("irq clr", irq, 32'h0);
			fb(3'h0, 4'h0, 16'sh0000, 32'sh0);
			step(4);
			chk("acc off", {afl, afa}, 32'h0);
		end
		// lower window bound reads back as written
		wr(8'h14, 32'h0064);
		wr(8'h18, 32'hff9c);
		rd(8'h18, 32'hff9c);
		// increment monitor 0 from safe input 2, window 997..1005, 5 ms delay
		wr(8'h40, 32'h0a);
		wr(8'h44, 32'h5);
		wr(8'h48, 32'h3);
		wr(8'h4c, 32'h5);
		wr(8'h50, 32'h1);
		fb(3'h0, 4'h4, 16'sh0000, 32'sh3e8);
		step(6);
		chk("inc act", ifl, 32'h1);
		chk("pto off", pto, 32'h0);
		wr(8'h0c, 32'h104);
		step(2);
		chk("pto pair", pto, 32'h3);
		fb(3'h0, 4'h4, 16'sh0000, 32'sh3de);
		step(5);
		chk("inc delay", ifa, 32'h0);
		fb(3'h0, 4'h4, 16'sh0000, 32'sh3e5);
		step(60);
		chk("inc low", ifa, 32'h0);
		fb(3'h0, 4'h4, 16'sh0000, 32'sh3ed);
		step(4);
		chk("inc high", ifa, 32'h0);
		fb(3'h0, 4'h4, 16'sh0000, 32'sh3ee);
		step(4);
		chk("inc flt", ifa, 32'h1);
		chk("inc torque", tq, 32'h1);
		rd(8'h00, 32'h8);
		fb(3'h0, 4'h0, 16'sh0000, 32'sh3ee);
		step(8);
		chk("inc off", {ifl, ifa, pto}, 32'h0);
		// increment instance 1 by fieldbus, zero delay, window 1005..1007, irq masked
		wr(8'h04, 32'h07);
		@(posedge clk_sys);
		partner_u.drive(3'h0, 3'h2, 4'h0, 16'sh0000, 32'sh3ee);
		step(4);
		chk("inc bus", ifl, 32'h2);
		wr(8'h0c, 32'h3d);
		step(2);
		chk("pto sel", pto, 32'h1);
		@(posedge clk_sys);
		partner_u.drive(3'h0, 3'h2, 4'h0, 16'sh0000, 32'sh3f0);
		step(4);
		chk("inc bus flt", {ifa, irq}, 32'h4);
		rd(8'h00, 32'h10);
		report_and_stop();
	end
endmodule
